// File: rtl/hca_alu.sv
`timescale 1ns/1ps
module hca_alu import hca_pkg::*; (
  // Operation select
  input wire hca_alu_e op_i,
  // Operands: a is accumulator or bit mask, b is file or literal
  input wire logic [HCA_DATA_W-1:0] a_i,
  input wire logic [HCA_DATA_W-1:0] b_i,
  input wire logic c_i,
  // Result and flags
  output logic [HCA_DATA_W-1:0] res_o,
  output logic c_o,
  output logic dc_o
);

  logic [HCA_DATA_W:0] sum9;
  logic [HCA_DATA_W:0] diff9;
  logic [4:0] nsum;
  logic [4:0] ndiff;

  // Two's complement adders, subtraction is b minus a
  assign sum9 = {1'b0, a_i} + {1'b0, b_i};
  assign diff9 = {1'b0, b_i} - {1'b0, a_i};
  assign nsum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
  assign ndiff = {1'b0, b_i[3:0]} - {1'b0, a_i[3:0]};

  // Operation mux, carry unchanged unless affected
  always_comb begin
    res_o = b_i;
    c_o = c_i;
    dc_o = 1'b0;
    case (op_i)
      HCA_ALU_ADD: begin
        res_o = sum9[HCA_DATA_W-1:0];
        c_o = sum9[HCA_DATA_W];
        dc_o = nsum[4];
      end
      HCA_ALU_SUB: begin
        res_o = diff9[HCA_DATA_W-1:0];
        c_o = ~diff9[HCA_DATA_W];
        dc_o = ~ndiff[4];
      end
      HCA_ALU_AND: res_o = a_i & b_i;
      HCA_ALU_IOR: res_o = a_i | b_i;
      HCA_ALU_XOR: res_o = a_i ^ b_i;
      HCA_ALU_COM: res_o = ~b_i;
      HCA_ALU_INC: res_o = b_i + HCA_BIT_ONE;
      HCA_ALU_DEC: res_o = b_i - HCA_BIT_ONE;
      HCA_ALU_RL: begin
        res_o = {b_i[HCA_DATA_W-2:0], c_i};
        c_o = b_i[HCA_DATA_W-1];
      end
      HCA_ALU_RR: begin
        res_o = {c_i, b_i[HCA_DATA_W-1:1]};
        c_o = b_i[0];
      end
      HCA_ALU_SWAP: res_o = {b_i[3:0], b_i[7:4]};
      HCA_ALU_PASSA: res_o = a_i;
      HCA_ALU_PASSB: res_o = b_i;
      HCA_ALU_CLR: res_o = HCA_BYTE_ZERO;
      default: res_o = b_i;
    endcase
  end

endmodule : hca_alu

// File: rtl/hca_core.sv
// Overview of operation
// - Fetch whole 14-bit word per instruction cycle
// - Two-stage pipeline, one cycle per instruction except branches
// - Eight-bit ALU: add, subtract, shift, logic
// - Arithmetic is two's complement
// - Two operands: accumulator plus file or literal
// - Single operand: accumulator or file register
// - Accumulator is eight bits, not addressable
// - ALU updates carry, nibble and zero flags
// - Subtraction flags are inverted borrow: set when no borrow
// - Special registers mapped, direct and indirect
// - Any operation works on any register
// - Internal 1K by 14 program memory only
// - RC mode drives clock output at quarter rate
// - Low master reset pin resets the core
// - Four phases per instruction cycle
// - Operand read phase two, write phase four
// - Branches flush prefetched word, take two cycles
`timescale 1ns/1ps
module hca_core import hca_pkg::*; #(
  parameter int PC_W = HCA_PC_W,
  parameter int STACK_DEPTH = HCA_STACK_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Pins
  input wire logic master_reset_n_i,
  input wire logic rc_mode_i,
  // Program memory load port
  input wire logic prog_we_i,
  input wire logic [PC_W-1:0] prog_waddr_i,
  input wire logic [HCA_INSTR_W-1:0] prog_wdata_i,
  // Clock output and core state
  output logic oscillator_output_o,
  output logic [PC_W-1:0] pc_o,
  output logic [HCA_DATA_W-1:0] w_o,
  output logic [HCA_DATA_W-1:0] status_o,
  output logic [HCA_INSTR_W-1:0] instr_o
);

  localparam int SP_W = $clog2(STACK_DEPTH);
  localparam int PMEM_DEPTH = 2 ** PC_W;

  // Parameter sanity
  if (PC_W < 9 || PC_W > 10) $error("hca_core: PC_W must be 9 or 10");
  if (STACK_DEPTH < 2 || (2 ** SP_W) != STACK_DEPTH) $error("hca_core: bad STACK_DEPTH");
  if (HCA_CLKS_PER_CYCLE != 4) $error("hca_core: phase count must be four");

  logic [2:0] master_reset_n_sync_ff, rcm_sync_ff;
  logic master_reset_n_lvl_ff, rcm_lvl_ff, osc_ff;
  hca_phase_e phase_ff;
  logic [HCA_INSTR_W-1:0] pmem [PMEM_DEPTH];
  logic [HCA_DATA_W-1:0] dmem [2 ** HCA_FADDR_W];
  logic [PC_W-1:0] stack_ff [STACK_DEPTH];
  logic [PC_W-1:0] pc_ff, fetch_addr_ff;
  logic [SP_W-1:0] sp_ff;
  logic [HCA_INSTR_W-1:0] ir_ff, fetch_word;
  logic [HCA_DATA_W-1:0] w_ff, status_ff, fsr_ff, pclath_ff, opnd_ff, res_ff;
  logic flag_c_ff, flag_dc_ff;
  logic core_run;

  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      master_reset_n_sync_ff <= 3'h0;
      rcm_sync_ff <= 3'h0;
      master_reset_n_lvl_ff <= 1'b0;
      rcm_lvl_ff <= 1'b0;
    end else begin
      master_reset_n_sync_ff <= {master_reset_n_sync_ff[1:0], master_reset_n_i};
      rcm_sync_ff <= {rcm_sync_ff[1:0], rc_mode_i};
      if (master_reset_n_sync_ff[1] == master_reset_n_sync_ff[2]) master_reset_n_lvl_ff <= master_reset_n_sync_ff[2];
      if (rcm_sync_ff[1] == rcm_sync_ff[2]) rcm_lvl_ff <= rcm_sync_ff[2];
    end
  end

  assign core_run = master_reset_n_lvl_ff;

  // Quadrature phase sequencer
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_ff <= HCA_Q1;
    end else if (!core_run) begin
      phase_ff <= HCA_Q1;
    end else begin
      case (phase_ff)
        HCA_Q1: phase_ff <= HCA_Q2;
        HCA_Q2: phase_ff <= HCA_Q3;
        HCA_Q3: phase_ff <= HCA_Q4;
        HCA_Q4: phase_ff <= HCA_Q1;
        default: phase_ff <= HCA_Q1;
      endcase
    end
  end

  // Clock output, high in Q4 and Q1 (registered from Q3 and Q4) when in RC mode
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) osc_ff <= 1'b0;
    else osc_ff <= rcm_lvl_ff && core_run && (phase_ff == HCA_Q3 || phase_ff == HCA_Q4);
  end

  // Internal program store, loaded through the programming port
  always_ff @(posedge clk_sys_i) begin
    if (prog_we_i) pmem[prog_waddr_i] <= prog_wdata_i;
  end
  assign fetch_word = pmem[fetch_addr_ff];

  // Instruction fields
  logic [1:0] cls;
  logic [3:0] sub;
  logic dest_f;
  logic [6:0] faddr, eff_addr;
  logic [HCA_DATA_W-1:0] lit, mask, rd_data, alu_a, alu_b, alu_res;
  logic alu_c, alu_dc;
  assign cls = ir_ff[13:12];
  assign sub = ir_ff[11:8];
  assign dest_f = ir_ff[7];
  assign faddr = ir_ff[6:0];
  assign lit = ir_ff[7:0];
  assign mask = HCA_DATA_W'(HCA_BIT_ONE << ir_ff[9:7]);
  assign eff_addr = (faddr == HCA_ADDR_INDIRECT) ? fsr_ff[6:0] : faddr;

  // File read, special registers mapped alongside RAM
  always_comb begin
    case (eff_addr)
      HCA_ADDR_INDIRECT: rd_data = HCA_BYTE_ZERO;
      HCA_ADDR_PCL: rd_data = pc_ff[7:0];
      HCA_ADDR_STATUS: rd_data = status_ff;
      HCA_ADDR_FSR: rd_data = fsr_ff;
      HCA_ADDR_PCLATH: rd_data = pclath_ff;
      default: rd_data = dmem[eff_addr];
    endcase
  end

  // Decode
  hca_alu_e alu_op;
  logic use_lit, use_mask, wr_w, wr_f, upd_c, upd_dc, upd_z;
  logic skip_z, skip_nz, br_goto, br_call, br_ret;
  always_comb begin
    alu_op = HCA_ALU_PASSB;
    use_lit = 1'b0;
    use_mask = 1'b0;
    wr_w = 1'b0;
    wr_f = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    skip_z = 1'b0;
    skip_nz = 1'b0;
    br_goto = 1'b0;
    br_call = 1'b0;
    br_ret = 1'b0;
    case (cls)
      HCA_CLS_BYTE: begin
        wr_f = dest_f;
        wr_w = !dest_f;
        upd_z = 1'b1;
        case (sub)
          HCA_B_MOVWF: begin
            alu_op = HCA_ALU_PASSA;
            wr_f = 1'b1;
            wr_w = 1'b0;
            upd_z = 1'b0;
          end
          HCA_B_CLR: alu_op = HCA_ALU_CLR;
          HCA_B_SUB: begin
            alu_op = HCA_ALU_SUB;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          HCA_B_DEC: alu_op = HCA_ALU_DEC;
          HCA_B_IOR: alu_op = HCA_ALU_IOR;
          HCA_B_AND: alu_op = HCA_ALU_AND;
          HCA_B_XOR: alu_op = HCA_ALU_XOR;
          HCA_B_ADD: begin
            alu_op = HCA_ALU_ADD;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          HCA_B_MOV: alu_op = HCA_ALU_PASSB;
          HCA_B_COM: alu_op = HCA_ALU_COM;
          HCA_B_INC: alu_op = HCA_ALU_INC;
          HCA_B_DECSZ, HCA_B_INCSZ: begin
            alu_op = (sub == HCA_B_DECSZ) ? HCA_ALU_DEC : HCA_ALU_INC;
            upd_z = 1'b0;
            skip_z = 1'b1;
          end
          HCA_B_RR, HCA_B_RL: begin
            alu_op = (sub == HCA_B_RR) ? HCA_ALU_RR : HCA_ALU_RL;
            upd_z = 1'b0;
            upd_c = 1'b1;
          end
          HCA_B_SWAP: begin
            alu_op = HCA_ALU_SWAP;
            upd_z = 1'b0;
          end
          default: alu_op = HCA_ALU_PASSB;
        endcase
      end
      HCA_CLS_BIT: begin
        use_mask = 1'b1;
        alu_op = (sub[3:2] == HCA_T_SET) ? HCA_ALU_IOR : HCA_ALU_AND;
        wr_f = (sub[3:2] == HCA_T_CLR) || (sub[3:2] == HCA_T_SET);
        skip_z = (sub[3:2] == HCA_T_SKIPCLR);
        skip_nz = (sub[3:2] == HCA_T_SKIPSET);
      end
      HCA_CLS_CTRL: begin
        br_goto = (sub[3:2] == HCA_C_GOTO);
        br_call = (sub[3:2] == HCA_C_CALL);
        br_ret = (sub[3:2] == HCA_C_RET);
      end
      HCA_CLS_LIT: begin
        use_lit = 1'b1;
        wr_w = 1'b1;
        upd_z = 1'b1;
        case (sub)
          HCA_L_MOV: upd_z = 1'b0;
          HCA_L_RET: begin
            upd_z = 1'b0;
            br_ret = 1'b1;
          end
          HCA_L_IOR: alu_op = HCA_ALU_IOR;
          HCA_L_AND: alu_op = HCA_ALU_AND;
          HCA_L_XOR: alu_op = HCA_ALU_XOR;
          HCA_L_SUB, HCA_L_ADD: begin
            alu_op = (sub == HCA_L_SUB) ? HCA_ALU_SUB : HCA_ALU_ADD;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          default: wr_w = 1'b0;
        endcase
      end
      default: alu_op = HCA_ALU_PASSB;
    endcase
  end

  // Operand steering into the ALU
  assign alu_a = use_mask ? ((sub[3:2] == HCA_T_CLR) ? ~mask : mask) : w_ff;
  assign alu_b = use_lit ? lit : opnd_ff;

  hca_alu u_alu (
    .op_i(alu_op),
    .a_i(alu_a),
    .b_i(alu_b),
    .c_i(status_ff[HCA_STAT_C]),
    .res_o(alu_res),
    .c_o(alu_c),
    .dc_o(alu_dc)
  );

  // Branch and skip decision, valid in Q4
  logic res_zero, pcl_wr, skip_hit, take_br;
  assign res_zero = (res_ff == HCA_BYTE_ZERO);
  assign pcl_wr = wr_f && (eff_addr == HCA_ADDR_PCL);
  assign skip_hit = (skip_z && res_zero) || (skip_nz && !res_zero);
  assign take_br = br_goto || br_call || br_ret || pcl_wr || skip_hit;

  // Operand read in Q2, ALU result captured in Q3
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      opnd_ff <= HCA_BYTE_ZERO;
      res_ff <= HCA_BYTE_ZERO;
      flag_c_ff <= 1'b0;
      flag_dc_ff <= 1'b0;
    end else begin
      if (phase_ff == HCA_Q2) opnd_ff <= rd_data;
      if (phase_ff == HCA_Q3) begin
        res_ff <= alu_res;
        flag_c_ff <= alu_c;
        flag_dc_ff <= alu_dc;
      end
    end
  end

  // Fetch: PC steps in Q1, word latched in Q4, flushed on a branch
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pc_ff <= PC_W'(HCA_PC_RST);
      fetch_addr_ff <= PC_W'(HCA_PC_RST);
      ir_ff <= HCA_INSTR_NOP;
      sp_ff <= '0;
    end else if (!core_run) begin
      pc_ff <= PC_W'(HCA_PC_RST);
      fetch_addr_ff <= PC_W'(HCA_PC_RST);
      ir_ff <= HCA_INSTR_NOP;
      sp_ff <= '0;
    end else if (phase_ff == HCA_Q1) begin
      fetch_addr_ff <= pc_ff;
      pc_ff <= pc_ff + PC_W'(1);
    end else if (phase_ff == HCA_Q4) begin
      ir_ff <= take_br ? HCA_INSTR_NOP : fetch_word;
      if (br_goto || br_call) pc_ff <= PC_W'(ir_ff[9:0]);
      if (br_call) sp_ff <= sp_ff + SP_W'(1);
      if (br_ret) begin
        pc_ff <= stack_ff[sp_ff - SP_W'(1)];
        sp_ff <= sp_ff - SP_W'(1);
      end
      if (pcl_wr) pc_ff <= {pclath_ff[PC_W-9:0], res_ff};
    end
  end

  // Return address stack, circular
  always_ff @(posedge clk_sys_i) begin
    if (core_run && phase_ff == HCA_Q4 && br_call) stack_ff[sp_ff] <= fetch_addr_ff;
  end

  // Destination write in Q4: accumulator, RAM or mapped registers
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      w_ff <= HCA_BYTE_ZERO;
      fsr_ff <= HCA_BYTE_ZERO;
      pclath_ff <= HCA_BYTE_ZERO;
    end else if (!core_run) begin
      w_ff <= HCA_BYTE_ZERO;
      fsr_ff <= HCA_BYTE_ZERO;
      pclath_ff <= HCA_BYTE_ZERO;
    end else if (phase_ff == HCA_Q4) begin
      if (wr_w) w_ff <= res_ff;
      if (wr_f && eff_addr == HCA_ADDR_FSR) fsr_ff <= res_ff;
      if (wr_f && eff_addr == HCA_ADDR_PCLATH) pclath_ff <= res_ff;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (core_run && phase_ff == HCA_Q4 && wr_f) dmem[eff_addr] <= res_ff;
  end

  // Status: flag updates override a direct write to the register
  logic [HCA_DATA_W-1:0] nxt_status;
  always_comb begin
    nxt_status = status_ff;
    if (wr_f && eff_addr == HCA_ADDR_STATUS) nxt_status = res_ff;
    if (upd_c) nxt_status[HCA_STAT_C] = flag_c_ff;
    if (upd_dc) nxt_status[HCA_STAT_NIBBLE] = flag_dc_ff;
    if (upd_z) nxt_status[HCA_STAT_Z] = res_zero;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) status_ff <= HCA_STATUS_RST;
    else if (!core_run) status_ff <= HCA_STATUS_RST;
    else if (phase_ff == HCA_Q4) status_ff <= nxt_status;
  end

  // Outputs straight from flops
  assign oscillator_output_o = osc_ff;
  assign pc_o = pc_ff;
  assign w_o = w_ff;
  assign status_o = status_ff;
  assign instr_o = ir_ff;

  // Independent nibble sum for the nibble flag check
  logic [4:0] nsum_chk;
  assign nsum_chk = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  AST_PHASE_ORDER: assert property (
    (phase_ff == HCA_Q1 && core_run) ##1 core_run[*3] |-> phase_ff == HCA_Q4)
    else $error("phase sequence broken");
  AST_OSC_QUARTER: assert property (
    $rose(osc_ff) ##1 (rcm_lvl_ff && core_run)[*4] |-> $rose(osc_ff))
    else $error("clock output not quarter rate");
  AST_FETCH_WORD: assert property (
    (core_run && phase_ff == HCA_Q4 && !take_br) |=> ir_ff == $past(fetch_word))
    else $error("fetched word not latched");
  AST_FLUSH: assert property (
    (core_run && phase_ff == HCA_Q4 && take_br) |=> ir_ff == HCA_INSTR_NOP)
    else $error("prefetch not flushed");
  AST_PC_STEP: assert property (
    (core_run && phase_ff == HCA_Q1) |=> pc_ff == $past(pc_ff) + PC_W'(1))
    else $error("pc did not step");
  AST_OPND_Q2: assert property (
    (phase_ff == HCA_Q2) |=> opnd_ff === $past(rd_data))
    else $error("operand not read in Q2");
  AST_ZERO_FLAG: assert property (
    (core_run && phase_ff == HCA_Q4 && upd_z) |=> status_ff[HCA_STAT_Z] == $past(res_zero))
    else $error("zero flag wrong");
  AST_SUB_BORROW: assert property (
    (phase_ff == HCA_Q3 && alu_op == HCA_ALU_SUB) |=> flag_c_ff == ($past(alu_b) >= $past(alu_a)))
    else $error("borrow flag wrong");
  AST_NIBBLE: assert property (
    (phase_ff == HCA_Q3 && alu_op == HCA_ALU_ADD)
    |=> flag_dc_ff == $past(nsum_chk[4]))
    else $error("nibble flag wrong");
  AST_W_HOLD: assert property (
    (core_run && phase_ff == HCA_Q4 && !wr_w) |=> $stable(w_ff))
    else $error("accumulator changed without a write");
  AST_MASTER_RESET_N: assert property (
    !core_run |=> pc_ff == PC_W'(HCA_PC_RST) && ir_ff == HCA_INSTR_NOP)
    else $error("core not held in reset");

  COV_BRANCH: cover property (core_run && phase_ff == HCA_Q4 && (br_goto || br_call));
  COV_SKIP: cover property (core_run && phase_ff == HCA_Q4 && skip_hit);
  COV_BORROW: cover property (phase_ff == HCA_Q3 && alu_op == HCA_ALU_SUB && !alu_c);
  COV_OSC: cover property ($rose(osc_ff));

endmodule : hca_core

// File: rtl/hca_pkg.sv
package hca_pkg;

  // Datapath and memory geometry
  localparam int HCA_DATA_W = 8;
  localparam int HCA_INSTR_W = 14;
  localparam int HCA_PC_W = 10;
  localparam int HCA_FADDR_W = 7;
  localparam int HCA_STACK_DEPTH = 8;

  // Instruction cycle timing: 400 ns at a 10 MHz input clock
  localparam int HCA_INSTR_CYCLE_NS = 400;
  localparam int HCA_REF_CLK_MHZ = 10;
  localparam int HCA_CLKS_PER_CYCLE = HCA_INSTR_CYCLE_NS * HCA_REF_CLK_MHZ / 1000;

  // Mapped special function register addresses
  localparam logic [6:0] HCA_ADDR_INDIRECT = 7'h00;
  localparam logic [6:0] HCA_ADDR_PCL = 7'h02;
  localparam logic [6:0] HCA_ADDR_STATUS = 7'h03;
  localparam logic [6:0] HCA_ADDR_FSR = 7'h04;
  localparam logic [6:0] HCA_ADDR_PCLATH = 7'h0A;

  // Status flag positions and reset values
  localparam int HCA_STAT_C = 0;
  localparam int HCA_STAT_NIBBLE = 1;
  localparam int HCA_STAT_Z = 2;
  localparam logic [7:0] HCA_STATUS_RST = 8'h00;
  localparam logic [7:0] HCA_BYTE_ZERO = 8'h00;
  localparam logic [7:0] HCA_BIT_ONE = 8'h01;
  localparam logic [9:0] HCA_PC_RST = 10'h000;

  // Instruction classes in bits 13:12
  localparam logic [1:0] HCA_CLS_BYTE = 2'h0;
  localparam logic [1:0] HCA_CLS_BIT = 2'h1;
  localparam logic [1:0] HCA_CLS_CTRL = 2'h2;
  localparam logic [1:0] HCA_CLS_LIT = 2'h3;
  localparam logic [13:0] HCA_INSTR_NOP = 14'h2C00;

  // Byte-oriented sub-opcodes in bits 11:8
  localparam logic [3:0] HCA_B_MOVWF = 4'h0;
  localparam logic [3:0] HCA_B_CLR = 4'h1;
  localparam logic [3:0] HCA_B_SUB = 4'h2;
  localparam logic [3:0] HCA_B_DEC = 4'h3;
  localparam logic [3:0] HCA_B_IOR = 4'h4;
  localparam logic [3:0] HCA_B_AND = 4'h5;
  localparam logic [3:0] HCA_B_XOR = 4'h6;
  localparam logic [3:0] HCA_B_ADD = 4'h7;
  localparam logic [3:0] HCA_B_MOV = 4'h8;
  localparam logic [3:0] HCA_B_COM = 4'h9;
  localparam logic [3:0] HCA_B_INC = 4'hA;
  localparam logic [3:0] HCA_B_DECSZ = 4'hB;
  localparam logic [3:0] HCA_B_RR = 4'hC;
  localparam logic [3:0] HCA_B_RL = 4'hD;
  localparam logic [3:0] HCA_B_SWAP = 4'hE;
  localparam logic [3:0] HCA_B_INCSZ = 4'hF;

  // Bit and control sub-opcodes in bits 11:10
  localparam logic [1:0] HCA_T_CLR = 2'h0;
  localparam logic [1:0] HCA_T_SET = 2'h1;
  localparam logic [1:0] HCA_T_SKIPCLR = 2'h2;
  localparam logic [1:0] HCA_T_SKIPSET = 2'h3;
  localparam logic [1:0] HCA_C_GOTO = 2'h0;
  localparam logic [1:0] HCA_C_CALL = 2'h1;
  localparam logic [1:0] HCA_C_RET = 2'h2;

  // Literal sub-opcodes in bits 11:8
  localparam logic [3:0] HCA_L_MOV = 4'h0;
  localparam logic [3:0] HCA_L_RET = 4'h1;
  localparam logic [3:0] HCA_L_IOR = 4'h8;
  localparam logic [3:0] HCA_L_AND = 4'h9;
  localparam logic [3:0] HCA_L_XOR = 4'hA;
  localparam logic [3:0] HCA_L_SUB = 4'hC;
  localparam logic [3:0] HCA_L_ADD = 4'hE;

  typedef enum logic [1:0] {HCA_Q1, HCA_Q2, HCA_Q3, HCA_Q4} hca_phase_e;

  typedef enum logic [3:0] {
    HCA_ALU_ADD, HCA_ALU_SUB, HCA_ALU_AND, HCA_ALU_IOR, HCA_ALU_XOR,
    HCA_ALU_COM, HCA_ALU_INC, HCA_ALU_DEC, HCA_ALU_RL, HCA_ALU_RR,
    HCA_ALU_SWAP, HCA_ALU_PASSA, HCA_ALU_PASSB, HCA_ALU_CLR
  } hca_alu_e;

endpackage : hca_pkg

// File: tb/harvard_core_alu_datapath_test.sv
`timescale 1ns/1ps
module harvard_core_alu_datapath_test import hca_pkg::*;;
  // Clock, reset and pins
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic master_reset_n_i = 1'b0;
  logic rc_mode_i = 1'b0;
  logic prog_we, osc_out;
  logic [HCA_PC_W-1:0] prog_waddr, pc;
  logic [HCA_INSTR_W-1:0] prog_wdata, instr;
  logic [HCA_DATA_W-1:0] w, status;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;

  // 200 MHz clock and cycle count
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) cyc <= cyc + 1;

  // Design and program store partner
  hca_core dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .master_reset_n_i(master_reset_n_i), .rc_mode_i(rc_mode_i), .prog_we_i(prog_we),
    .prog_waddr_i(prog_waddr), .prog_wdata_i(prog_wdata), .oscillator_output_o(osc_out),
    .pc_o(pc), .w_o(w), .status_o(status), .instr_o(instr));
  hca_prog_loader prog_u (.clk_sys_i(clk_sys_i), .prog_we_o(prog_we),
    .prog_waddr_o(prog_waddr), .prog_wdata_o(prog_wdata));

  // Compare tasks
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_word(input logic [13:0] got, input logic [13:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_cnt(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // Hold core in pin reset, load, release, run
  task automatic run_prog(input logic [13:0] img[$], input int ncyc);
    @(posedge clk_sys_i);
    master_reset_n_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    prog_u.load(img);
    @(posedge clk_sys_i);
    master_reset_n_i <= 1'b1;
    repeat (ncyc) @(posedge clk_sys_i);
    #1;
  endtask : run_prog

  // Bounded wait for a word in the instruction register
  task automatic wait_instr(input logic [13:0] word, output int t);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (instr === word) begin
        t = cyc;
        return;
      end
    end
    failures++;
    $display("ERROR t=%0t got=%h exp=%h", $time, instr, word);
    wrap_up();
  endtask : wait_instr

  // Literal ALU ops: carry, nibble and zero on boundaries
  task automatic scn_literal_alu;
    logic [7:0] wi[8] = '{8'h0F, 8'hFF, 8'h01, 8'h02, 8'h05, 8'hF0, 8'h50, 8'hFF};
    logic [13:0] op[8] = '{14'h3E01, 14'h3E01, 14'h3C10, 14'h3C01, 14'h3C05, 14'h390F,
      14'h380A, 14'h3AFF};
    logic [7:0] ew[8] = '{8'h10, 8'h00, 8'h0F, 8'hFF, 8'h00, 8'h00, 8'h5A, 8'h00};
    logic [7:0] es[8] = '{8'h02, 8'h07, 8'h01, 8'h00, 8'h07, 8'h04, 8'h00, 8'h04};
    for (int i = 0; i < 8; i++) begin
      run_prog('{14'h3000 | {6'h00, wi[i]}, op[i], 14'h2002}, 40);
      chk_byte(w, ew[i]);
      chk_byte(status, es[i]);
    end
  endtask : scn_literal_alu

  // File ops: store, rotate, add from file, indirect read
  task automatic scn_file_ops;
    run_prog('{14'h3081, 14'h00A0, 14'h0D20, 14'h0720, 14'h00A1, 14'h3021, 14'h0084,
      14'h0800, 14'h2008}, 60);
    chk_byte(w, 8'h83);
    chk_byte(status, 8'h00);
  endtask : scn_file_ops

  // Call, bit set and clear, taken skip, literal return, swap, subtract from file
  task automatic scn_call_bits;
    run_prog('{14'h30A5, 14'h00A2, 14'h2407, 14'h0EA2, 14'h0222, 14'h2005, 14'h2005,
      14'h15A2, 14'h1022, 14'h1822, 14'h0AA2, 14'h3155}, 80);
    chk_byte(w, 8'h75);
    chk_byte(status, 8'h03);
  endtask : scn_call_bits

  // Pipeline: one cycle per word, goto flushes prefetch
  task automatic scn_branch_timing;
    int t0;
    int t1;
    int t2;
    run_prog('{14'h3001, 14'h3002, 14'h2004, 14'h30EE, 14'h3004, 14'h2005}, 0);
    wait_instr(14'h3001, t0);
    wait_instr(14'h3002, t1);
    chk_byte(w, 8'h01);
    wait_instr(14'h3004, t2);
    chk_cnt(t1 - t0, HCA_CLKS_PER_CYCLE);
    chk_cnt(t2 - t1, 3 * HCA_CLKS_PER_CYCLE);
    repeat (8) @(posedge clk_sys_i);
    #1;
    chk_byte(w, 8'h04);
  endtask : scn_branch_timing

  // Clock output in both modes, then pin reset mid-run
  task automatic scn_clkout_reset;
    int rises;
    int highs;
    logic prev;
    for (int m = 1; m >= 0; m--) begin
      @(posedge clk_sys_i);
      rc_mode_i <= m[0];
      repeat (8) @(posedge clk_sys_i);
      #1;
      rises = 0;
      highs = 0;
      prev = osc_out;
      repeat (16) begin
        @(posedge clk_sys_i);
        #1;
        if (osc_out === 1'b1) highs++;
        if (osc_out === 1'b1 && prev === 1'b0) rises++;
        prev = osc_out;
      end
      chk_cnt(rises, 4 * m);
      chk_cnt(highs, 8 * m);
    end
    @(posedge clk_sys_i);
    master_reset_n_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    #1;
    chk_word({4'h0, pc}, 14'h0000);
    chk_byte(w, 8'h00);
    chk_word(instr, HCA_INSTR_NOP);
  endtask : scn_clkout_reset

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk_word(instr, HCA_INSTR_NOP);
    @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    scn_literal_alu();
    scn_file_ops();
    scn_call_bits();
    scn_branch_timing();
    scn_clkout_reset();
    wrap_up();
  end
endmodule : harvard_core_alu_datapath_test

// File: tb/hca_prog_loader.sv
`timescale 1ns/1ps
module hca_prog_loader import hca_pkg::*; (
  // Clock
  input wire logic clk_sys_i,
  // Program store load port
  output logic prog_we_o,
  output logic [HCA_PC_W-1:0] prog_waddr_o,
  output logic [HCA_INSTR_W-1:0] prog_wdata_o
);
  // Load port idle at start
  initial begin
    prog_we_o = 1'b0;
    prog_waddr_o = '0;
    prog_wdata_o = '0;
  end

  // Burst words from address 0; strobe held high across the burst
  task automatic load(input logic [HCA_INSTR_W-1:0] img[$]);
    for (int i = 0; i < img.size(); i++) begin
      @(posedge clk_sys_i);
      prog_we_o <= 1'b1;
      prog_waddr_o <= HCA_PC_W'(i);
      prog_wdata_o <= img[i];
    end
    @(posedge clk_sys_i);
    prog_we_o <= 1'b0;
    prog_wdata_o <= ~prog_wdata_o; // Stale data never looks valid
  endtask : load
endmodule : hca_prog_loader
